// ### dv/host_bus_model.sv
// host processor model driving the byte-wide register bus
`timescale 1ns/1ps
module host_bus_model
(
  // clock
  input wire logic i_clk_sys,
  // bus toward the port
  output logic [1:0] o_sel,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  initial
  begin
    o_sel = 2'h2;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end

  // one strobe per byte; a released data bus shows the inverse, not stale
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_sel <= sel;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_sel <= sel;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    @(posedge i_clk_sys);
    d = i_rdata;
  endtask
endmodule

// ### dv/pio_sample_byte_port_test.sv
// self-checking bench for the sample byte port
`timescale 1ns/1ps
module pio_sample_byte_port_test
  import pio_port_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] sel;
  logic rd, wr;
  logic [7:0] wdata, rdata, d;
  logic init = 1'b0;
  logic sixteen = 1'b1;
  logic stereo = 1'b0;
  logic over_under = 1'b1;
  logic irq = 1'b0;
  logic adc_new = 1'b0;
  logic dac_take = 1'b0;
  logic [31:0] adc_sample = 32'h0;
  logic [31:0] dac_sample, s, mask;
  logic dac_ready, boost;
  logic [3:0] gain;
  logic [1:0] src;
  logic [7:0] db10;
  int bad_count = 0;
  int n_tests = 0;
  int n, j;
  // data byte beside expected gain in tenths of a dB; bit 4 kept 0
  logic [15:0] rows [4] = '{16'hef_e1, 16'ha5_ff, 16'h43_2d, 16'h8a_96};

  always #4 clk = ~clk;

  host_bus_model host_bus_model_i (.i_clk_sys(clk), .o_sel(sel),
    .o_rd(rd), .o_wr(wr), .o_wdata(wdata), .i_rdata(rdata));

  pio_sample_byte_port pio_sample_byte_port_i (.i_clk_sys(clk),
    .i_rst_n(rst_n), .i_direct_select(sel), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdata), .o_rdata(rdata), .i_initializing(init),
    .i_sixteen_bit(sixteen), .i_stereo(stereo),
    .i_over_under(over_under), .i_irq_state(irq), .i_adc_new(adc_new),
    .i_adc_sample(adc_sample), .i_dac_take(dac_take),
    .o_dac_sample(dac_sample), .o_dac_ready(dac_ready),
    .o_left_gain_step(gain), .o_left_mic_boost(boost),
    .o_left_source_pick(src), .o_left_gain_db10(db10));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic pulse_adc(input logic [31:0] smp);
    @(posedge clk);
    adc_sample <= smp;
    adc_new <= 1'b1;
    @(posedge clk);
    adc_new <= 1'b0;
  endtask

  // dac outputs are registered; one idle edge lets them settle before a look
  task automatic pulse_dac;
    @(posedge clk);
    dac_take <= 1'b1;
    @(posedge clk);
    dac_take <= 1'b0;
    @(posedge clk);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({src, boost, gain, dac_ready}, 0);
    host_bus_model_i.wr(ADDR_INDEX, {4'h0, IDX_LEFT_INPUT});
    host_bus_model_i.rd(ADDR_IDATA, d);
    check(d, LEFT_INPUT_RST);
    foreach (rows[k])
    begin
      host_bus_model_i.wr(ADDR_IDATA, rows[k][15:8]);
      host_bus_model_i.rd(ADDR_IDATA, d);
      check(d, rows[k][15:8]);
      check({src, boost, gain}, {rows[k][15:13], rows[k][11:8]});
      check(db10, rows[k][7:0]);
    end
    // every sample width: status, byte order, parking, dropped extra writes
    for (int m = 0; m < 4; m++)
    begin
      sixteen <= m[1];
      stereo <= m[0];
      n = m[1] ? (m[0] ? 4 : 2) : (m[0] ? 2 : 1);
      mask = 32'hffffffff >> (32 - 8 * n);
      s = 32'h44332211 << m;
      pulse_adc(s);
      host_bus_model_i.rd(ADDR_STATUS, d);
      check(d, {~m[1], 3'b111, ~m[1], 3'b100});
      for (int k = 0; k <= n; k++)
      begin
        j = (k < n) ? k : n - 1;
        host_bus_model_i.rd(ADDR_PIO, d);
        check(d, s[8 * j +: 8]);
      end
      for (int k = 0; k < n; k++)
        host_bus_model_i.wr(ADDR_PIO, 8'h5a + k[7:0]);
      host_bus_model_i.wr(ADDR_PIO, 8'hee);
      @(posedge clk);
      check(dac_ready, 1'b1);
      check(dac_sample & mask, 32'h5d5c5b5a & mask);
      pulse_dac();
      check(dac_ready, 1'b0);
      host_bus_model_i.wr(ADDR_PIO, 8'h77);
      @(posedge clk);
      check(dac_sample[7:0], 8'h77);
      pulse_dac();
    end
    // a new sample after the stream is drained restarts the parked capture pointer
    host_bus_model_i.rd(ADDR_PIO, d);
    pulse_adc(32'h88776655);
    host_bus_model_i.rd(ADDR_PIO, d);
    check(d, 8'h55);
    // while initializing: playback writes dropped, capture reads fixed
    sixteen <= 1'b0;
    stereo <= 1'b0;
    init <= 1'b1;
    host_bus_model_i.wr(ADDR_PIO, 8'h12);
    @(posedge clk);
    check(dac_ready, 1'b0);
    host_bus_model_i.rd(ADDR_PIO, d);
    check(d, INIT_READ);
    init <= 1'b0;
    tally_and_finish();
  end

  // the whole sequence needs well under 2000 cycles; this allows ten times
  initial
  begin
    #160000;
    bad_count++;
    tally_and_finish();
  end
endmodule

// ### hdl/byte_tracker.sv
// byte tracking state machine for one sample direction
`timescale 1ns/1ps
module byte_tracker
  import pio_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // control
  byte_track_if.trk bt,
  // whether a step past the end holds or parks
  input wire logic i_hold_last
);
  byte_state_t state_ff;
  byte_state_t nxt_state;
  logic [1:0] pos_ff;
  logic [1:0] nxt_pos;
  wire last_pos = (pos_ff == bt.nbytes - 2'h1);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    case (state_ff)
      BT_FIRST, BT_MID:
      begin
        if (bt.step && last_pos)
          nxt_state = i_hold_last ? BT_LAST : BT_DONE;
        else if (bt.step)
        begin
          nxt_pos = pos_ff + 2'h1;
          nxt_state = BT_MID;
        end
      end
      BT_LAST: nxt_state = BT_LAST;
      BT_DONE: nxt_state = BT_DONE;
      default: nxt_state = BT_FIRST;
    endcase
    if (bt.restart)
    begin
      nxt_state = BT_FIRST;
      nxt_pos = 2'h0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= BT_FIRST;
      pos_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
    end
  end

  assign bt.pos = pos_ff;
  assign bt.at_end = last_pos || state_ff == BT_LAST;
  assign bt.done = (state_ff == BT_DONE) || (state_ff == BT_LAST);

  restart_first_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    bt.restart |=> pos_ff == 2'h0 && state_ff == BT_FIRST)
    else $error("tracker not back at first byte");
endmodule

// ### hdl/left_input_ctl.sv
// left input control register and its decoded fields
`timescale 1ns/1ps
module left_input_ctl
  import pio_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // write port
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // register and fields
  output logic [7:0] o_value,
  output logic [3:0] o_left_gain_step,
  output logic o_left_mic_boost,
  output logic [1:0] o_left_source_pick,
  output logic [7:0] o_gain_db10
);
  logic [7:0] reg_ff;

  // reserved bit never stored so it reads zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      reg_ff <= LEFT_INPUT_RST;
    else if (i_wr)
      reg_ff <= i_wdata & LEFT_INPUT_WMASK;
  end

  assign o_value = reg_ff;
  assign o_left_gain_step = reg_ff[GAIN_LSB +: GAIN_W];
  assign o_left_mic_boost = reg_ff[BOOST_BIT];
  assign o_left_source_pick = reg_ff[SRC_LSB +: SRC_W];
  // total gain in tenths of a dB modulo 256, mic boost added only on the mic path
  wire [7:0] step_db10 = 8'(GAIN_STEP_DB10) * {4'h0, o_left_gain_step};
  wire mic_boost_on = o_left_mic_boost &&
    left_source_t'(o_left_source_pick) == SRC_MIC;
  assign o_gain_db10 = step_db10 + (mic_boost_on ? 8'(BOOST_DB10) : 8'h00);

  gain_cap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    step_db10 <= 8'(GAIN_MAX_DB10))
    else $error("gain step above maximum");
  boost_add_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mic_boost_on |-> o_gain_db10 == step_db10 + 8'(BOOST_DB10))
    else $error("mic boost missing");
  res_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_wr |=> !reg_ff[RES_BIT])
    else $error("reserved bit stored");
endmodule

// ### hdl/pio_sample_byte_port.sv
// top: byte-wide host port with pio sample data and left input control
`timescale 1ns/1ps
module pio_sample_byte_port
  import pio_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // host bus
  input wire logic [1:0] i_direct_select,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // device state
  input wire logic i_initializing,
  input wire logic i_sixteen_bit,
  input wire logic i_stereo,
  input wire logic i_over_under,
  input wire logic i_irq_state,
  // converter side
  input wire logic i_adc_new,
  input wire logic [31:0] i_adc_sample,
  input wire logic i_dac_take,
  output logic [31:0] o_dac_sample,
  output logic o_dac_ready,
  // left input controls
  output logic [3:0] o_left_gain_step,
  output logic o_left_mic_boost,
  output logic [1:0] o_left_source_pick,
  output logic [7:0] o_left_gain_db10
);
  byte_track_if cap_bt ();
  byte_track_if play_bt ();

  logic [3:0] indirect_index_ff;
  logic [7:0] index_hi_ff;
  logic [31:0] capture_ff;
  logic [31:0] playback_ff;
  logic capture_fresh_flag_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] left_value;

  // ---- decode
  wire active = !i_initializing;
  wire wr_index = i_wr && active && i_direct_select == ADDR_INDEX;
  wire wr_idata = i_wr && active && i_direct_select == ADDR_IDATA;
  wire wr_pio = i_wr && active && i_direct_select == ADDR_PIO;
  wire rd_pio = i_rd && active && i_direct_select == ADDR_PIO;
  wire wr_left = wr_idata && indirect_index_ff == IDX_LEFT_INPUT;
  wire [1:0] sample_bytes = {i_stereo, ~i_stereo} << i_sixteen_bit;

  function automatic logic [7:0] pick_byte(input logic [31:0] s,
                                           input logic [1:0] p);
    pick_byte = s[{p, 3'h0} +: 8];
  endfunction

  // ---- index register
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      indirect_index_ff <= 4'h0;
      index_hi_ff <= INDEX_RST;
    end
    else if (wr_index)
    begin
      indirect_index_ff <= i_wdata[3:0];
      index_hi_ff <= {i_wdata[7:4], 4'h0};
    end
  end

  left_input_ctl u_left (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_wr(wr_left),
    .i_wdata(i_wdata),
    .o_value(left_value),
    .o_left_gain_step(o_left_gain_step),
    .o_left_mic_boost(o_left_mic_boost),
    .o_left_source_pick(o_left_source_pick),
    .o_gain_db10(o_left_gain_db10)
  );

  // ---- capture path
  // bytes stored little-end first, ms byte of each word at odd positions
  assign cap_bt.step = rd_pio;
  assign cap_bt.restart = i_adc_new;
  assign cap_bt.nbytes = sample_bytes;

  byte_tracker u_cap (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .bt(cap_bt),
    .i_hold_last(1'b1)
  );

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      capture_ff <= 32'h0000_0000;
      capture_fresh_flag_ff <= 1'b0;
    end
    else if (i_adc_new)
    begin
      capture_ff <= i_adc_sample;
      capture_fresh_flag_ff <= 1'b1; // new sample wins over a read
    end
    else if (rd_pio && cap_bt.at_end)
      capture_fresh_flag_ff <= 1'b0;
  end

  // once drained the pointer sits on the last byte, the ms byte
  wire [7:0] cap_byte = pick_byte(capture_ff, cap_bt.pos);

  // ---- playback path
  assign play_bt.step = wr_pio;
  assign play_bt.restart = i_dac_take;
  assign play_bt.nbytes = sample_bytes;

  byte_tracker u_play (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .bt(play_bt),
    .i_hold_last(1'b0)
  );

  wire play_accept = wr_pio && !play_bt.done;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      playback_ff <= 32'h0000_0000;
    else if (play_accept)
      playback_ff[{play_bt.pos, 3'h0} +: 8] <= i_wdata;
  end

  assign o_dac_sample = playback_ff;
  assign o_dac_ready = play_bt.done;

  // ---- status: upper when 8-bit or on odd position
  wire cap_upper = !i_sixteen_bit || cap_bt.pos[0];
  wire play_upper = !i_sixteen_bit || play_bt.pos[0];
  wire cap_left = !i_stereo || (cap_bt.pos < (i_sixteen_bit ? 2'h2 : 2'h1));
  wire play_left = !i_stereo ||
    (play_bt.pos < (i_sixteen_bit ? 2'h2 : 2'h1));
  wire [7:0] status_val = {cap_upper, cap_left, capture_fresh_flag_ff,
    i_over_under, play_upper, play_left, play_bt.done, i_irq_state};

  // ---- read mux, registered
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (i_rd)
    begin
      if (!active)
        nxt_rdata = INIT_READ;
      else
      begin
        case (i_direct_select)
          ADDR_INDEX: nxt_rdata = index_hi_ff | {4'h0, indirect_index_ff};
          ADDR_IDATA: nxt_rdata = (indirect_index_ff == IDX_LEFT_INPUT) ?
            left_value : 8'h00;
          ADDR_STATUS: nxt_rdata = status_val;
          ADDR_PIO: nxt_rdata = cap_byte;
          default: nxt_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_rdata = rdata_ff;

  // ---- assertions
  init_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rd && i_initializing |=> o_rdata == INIT_READ)
    else $error("init read not 80h");
  init_nowrite_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    i_wr && i_initializing && !i_dac_take |=> $stable(play_bt.pos)
      && $stable(playback_ff))
    else $error("write taken while initializing");
  cap_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_pio && !cap_bt.at_end && !i_adc_new
      |=> cap_bt.pos == $past(cap_bt.pos) + 2'h1)
    else $error("capture pointer did not advance");
  cap_park_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_pio && cap_bt.at_end && !i_adc_new
      |=> $stable(cap_bt.pos) && !capture_fresh_flag_ff)
    else $error("capture pointer left last byte");
  cap_restart_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_adc_new |=> cap_bt.pos == 2'h0 && capture_fresh_flag_ff)
    else $error("capture not restarted");
  stale_msb_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_pio && !capture_fresh_flag_ff |=> o_rdata == $past(cap_byte))
    else $error("stale read wrong byte");
  play_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_pio && play_bt.done && !i_dac_take |=> $stable(playback_ff))
    else $error("extra playback write stored");
  play_restart_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    i_dac_take |=> play_bt.pos == 2'h0 && !o_dac_ready)
    else $error("playback not restarted");
  play_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    play_accept && !play_bt.at_end && !i_dac_take
      |=> play_bt.pos == $past(play_bt.pos) + 2'h1)
    else $error("playback pointer did not advance");

  fill_play_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    play_accept ##1 play_accept ##1 o_dac_ready);
  drain_cap_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_pio && cap_bt.at_end ##1 rd_pio);
  index_left_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_index ##[1:4] wr_left);
endmodule

// ### pkg/byte_track_if.sv
// interface: byte tracker control and position
`timescale 1ns/1ps
interface byte_track_if;
  logic step;
  logic restart;
  logic [1:0] nbytes;
  logic [1:0] pos;
  logic at_end;
  logic done;
  modport ctrl (output step, output restart, output nbytes,
    input pos, input at_end, input done);
  modport trk (input step, input restart, input nbytes,
    output pos, output at_end, output done);
endinterface

// ### pkg/pio_port_pkg.sv
// package: offsets, fields, reset values and states of the sample byte port
package pio_port_pkg;
  // direct addresses
  localparam logic [1:0] ADDR_INDEX = 2'h0;
  localparam logic [1:0] ADDR_IDATA = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_PIO = 2'h3;
  // indirect indexes
  localparam logic [3:0] IDX_LEFT_INPUT = 4'h0;
  // left input control fields
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 4;
  localparam int RES_BIT = 4;
  localparam int BOOST_BIT = 5;
  localparam int SRC_LSB = 6;
  localparam int SRC_W = 2;
  localparam logic [7:0] LEFT_INPUT_RST = 8'h00;
  localparam logic [7:0] LEFT_INPUT_WMASK = 8'hef;
  // status fields
  localparam int ST_CAP_HALF = 7;
  localparam int ST_CAP_CHAN = 6;
  localparam int ST_CAP_FRESH = 5;
  localparam int ST_OVER_UNDER = 4;
  localparam int ST_PLAY_HALF = 3;
  localparam int ST_PLAY_CHAN = 2;
  localparam int ST_PLAY_READY = 1;
  localparam int ST_IRQ = 0;
  // value read while initializing, and the index register reset value
  localparam logic [7:0] INIT_READ = 8'h80;
  localparam logic [7:0] INDEX_RST = 8'h40;
  // gain figures, in tenths of a dB
  localparam int GAIN_STEP_DB10 = 15;
  localparam int GAIN_MAX_DB10 = 225;
  localparam int BOOST_DB10 = 180;
  // left source choices
  typedef enum logic [1:0] {
    SRC_LINE,
    SRC_AUX1,
    SRC_MIC,
    SRC_DAC_MIX
  } left_source_t;
  // byte tracker states
  typedef enum logic [1:0] {
    BT_FIRST,
    BT_MID,
    BT_LAST,
    BT_DONE
  } byte_state_t;
endpackage
